// ---- core/sdm_pkg.sv ----
// sdm_pkg: frame layout, mode codes, reset values and link timing for the serial dac control.
// assumes a single 25 mhz system clock that oversamples the three-wire link.
// How it works
// - after reset the dac code is zero and the output is driven at zero volts until a good frame lands.
// - the operating mode comes from a two-bit field of the received word.
// - mode 00 is normal operation with the amplifier driving the output from the code.
// - any other mode disconnects the amplifier; modes 01 and 10 also connect a termination instead.
// - mode 01 is one kilohm to ground, mode 10 is one hundred kilohms, mode 11 is open.
// - bits 15 and 14 are ignored, bits 13 and 12 are the mode, bits 11 to 0 the code, msb first.
// - the code is unsigned straight binary from 0 to 4095.
// - a frame starts when select falls, bits are taken on falling shift clock edges, the 16th loads.
// - select rising before the 16th falling edge clears the shift state and drops the frame.
package sdm_pkg;
   localparam int          FRAME_BITS  = 16;
   localparam int          CODE_BITS   = 12;
   localparam int          MODE_HI_POS = 13;
   localparam int          MODE_LO_POS = 12;
   localparam int          CODE_MSB    = 11;
   localparam logic [11:0] CODE_RESET  = 12'h000;
   localparam logic [11:0] CODE_MAX    = 12'hFFF;
   localparam int          SYNC_HIGH_NS = 33;
   localparam int          CLK_NS       = 40;
   localparam int          SYNC_HIGH_CYC =
      ((SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS) < 1 ? 1 : ((SYNC_HIGH_NS + CLK_NS - 1) / CLK_NS);
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_PD_1K  = 2'b01,
      MODE_PD_100K = 2'b10,
      MODE_PD_HIZ = 2'b11
   } sdm_mode_t;
endpackage : sdm_pkg

// ---- core/sdm_top.sv ----
// sdm_top: receives 16-bit frames on the three-wire link and drives dac code and mode controls.
// assumes select, shift clock and data come from another clock domain and are synchronised here.
`timescale 1ns/1ps
module sdm_top (
   // system
   input  wire logic        clk,
   input  wire logic        rst_n,
   // serial link pins
   input  wire logic        sync_n,
   input  wire logic        sclk,
   input  wire logic        din,
   // dac controls
   output logic [11:0]      dac_code,
   output logic [1:0]       power_mode,
   output logic             amp_enable,
   output logic             term_1k_en,
   output logic             term_100k_en,
   output logic             load_pulse
);
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} sdm_state_t;

   logic [2:0]  sync_pipe_reg;
   logic [2:0]  sclk_pipe_reg;
   logic [1:0]  din_pipe_reg;
   logic [15:0] shift_reg;
   logic [4:0]  count_reg;
   logic [4:0]  count_next;
   logic [15:0] shift_next;
   sdm_state_t  state_reg;
   sdm_state_t  state_next;
   logic        loaded_reg;   // a complete frame has landed since reset

   // synchronised levels and edges; stage 0 only feeds stage 1
   wire sync_s    = sync_pipe_reg[1];
   wire sync_fall = sync_pipe_reg[2] & ~sync_pipe_reg[1];
   wire sync_rise = ~sync_pipe_reg[2] & sync_pipe_reg[1];
   wire sclk_fall = sclk_pipe_reg[2] & ~sclk_pipe_reg[1];
   wire din_s     = din_pipe_reg[1];
   wire take_bit  = (state_reg == ST_SHIFT) & ~sync_s & sclk_fall;
   wire last_bit  = take_bit & (count_reg == 5'(sdm_pkg::FRAME_BITS - 1));
   wire [15:0] word_next = {shift_reg[14:0], din_s}; // msb first
   wire [1:0]  mode_next = {word_next[sdm_pkg::MODE_HI_POS], word_next[sdm_pkg::MODE_LO_POS]};

   // two flop synchronisers, plus an edge stage on select and shift clock but not on data
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_pipe_reg <= 3'h7;
         sclk_pipe_reg <= 3'h7;   // matches the idle-high shift clock, no false fall
         din_pipe_reg  <= 2'h0;
      end else begin
         sync_pipe_reg <= {sync_pipe_reg[1:0], sync_n};
         sclk_pipe_reg <= {sclk_pipe_reg[1:0], sclk};
         din_pipe_reg  <= {din_pipe_reg[0], din};
      end
   end

   // next frame state; select high always returns to idle
   always_comb begin
      state_next = state_reg;
      if (sync_s) begin
         state_next = ST_IDLE;          // early rise drops the frame
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
               if (sync_fall) begin
                  state_next = ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (last_bit) begin
                  state_next = ST_DONE;
               end
            end
            ST_DONE: begin
               state_next = ST_DONE;     // extra edges ignored
            end
         endcase
      end
   end

   // bit counter and shift register: cleared while select is high, stepped per taken bit
   assign count_next = sync_s   ? 5'h00 :
                       take_bit ? count_reg + 5'h01 :
                                  count_reg;
   assign shift_next = sync_s   ? 16'h0000 :
                       take_bit ? word_next :
                                  shift_reg;

   // frame state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         count_reg <= 5'h00;
         shift_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         count_reg <= count_next;
         shift_reg <= shift_next;
      end
   end

   // decode of the incoming word for the output registers
   wire [sdm_pkg::CODE_BITS-1:0] code_next  = word_next[sdm_pkg::CODE_MSB:0];
   wire                          amp_next   = (mode_next == sdm_pkg::MODE_NORMAL);
   wire                          t1k_next   = (mode_next == sdm_pkg::MODE_PD_1K);
   wire                          t100k_next = (mode_next == sdm_pkg::MODE_PD_100K);

   // output registers load only on the 16th edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dac_code     <= sdm_pkg::CODE_RESET;
         power_mode   <= sdm_pkg::MODE_NORMAL;
         amp_enable   <= 1'b1;
         term_1k_en   <= 1'b0;
         term_100k_en <= 1'b0;
         load_pulse   <= 1'b0;
      end else begin
         load_pulse <= last_bit;
         if (last_bit) begin
            dac_code     <= code_next;   // straight binary
            power_mode   <= mode_next;
            amp_enable   <= amp_next;
            term_1k_en   <= t1k_next;
            term_100k_en <= t100k_next;
         end
      end
   end

   // remembers that a complete frame has landed since reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loaded_reg <= 1'b0;
      end else if (last_bit) begin
         loaded_reg <= 1'b1;
      end
   end

   // checks: steps of a frame as named sequences, properties built on them
   sequence s_load;
      last_bit ##1 load_pulse;
   endsequence

   sequence s_arm;
      (state_reg == ST_IDLE) && !sync_s && sync_fall;
   endsequence

   sequence s_abort;
      (state_reg == ST_SHIFT) && sync_s;
   endsequence

   sequence s_done_hold;
      (state_reg == ST_DONE) && !sync_s;
   endsequence

   // reset state and the load path
   a_reset_code_zero: assert property (@(posedge clk) disable iff (!rst_n)
      !loaded_reg |-> (dac_code == sdm_pkg::CODE_RESET) && amp_enable &&
                      (power_mode == sdm_pkg::MODE_NORMAL))
      else $error("output left zero scale before first frame");
   a_idle_count_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == ST_IDLE) |-> (count_reg == 5'h00))
      else $error("frame armed with a stale bit count");
   a_arm_on_fall: assert property (@(posedge clk) disable iff (!rst_n)
      s_arm |=> (state_reg == ST_SHIFT))
      else $error("select fall did not arm the frame");
   a_bit_shifts_in: assert property (@(posedge clk) disable iff (!rst_n)
      take_bit |=> (shift_reg == {$past(shift_reg[14:0]), $past(din_s)}))
      else $error("bit not shifted in msb first");
   a_last_to_done: assert property (@(posedge clk) disable iff (!rst_n)
      last_bit |=> (state_reg == ST_DONE) && (count_reg == 5'(sdm_pkg::FRAME_BITS)))
      else $error("sixteenth bit did not end the frame");
   a_pulse_follows_last: assert property (@(posedge clk) disable iff (!rst_n)
      last_bit |=> load_pulse)
      else $error("no load pulse after the sixteenth bit");
   a_load_updates_code: assert property (@(posedge clk) disable iff (!rst_n)
      s_load |-> (dac_code == $past(word_next[sdm_pkg::CODE_MSB:0])) &&
                 (power_mode == $past(mode_next)))
      else $error("code not loaded on last bit");
   a_load_needs_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
      load_pulse |-> (count_reg == 5'(sdm_pkg::FRAME_BITS)))
      else $error("load without sixteen bits");
   a_count_bounded: assert property (@(posedge clk) disable iff (!rst_n)
      count_reg <= 5'h10)
      else $error("bit count overran");
   a_pulse_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
      load_pulse |=> !load_pulse)
      else $error("load pulse too long");
   a_hold_without_load: assert property (@(posedge clk) disable iff (!rst_n)
      !last_bit |=> $stable(dac_code) && $stable(power_mode))
      else $error("outputs changed without a complete frame");
   a_mode_flags_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !last_bit |=> $stable(amp_enable) && $stable(term_1k_en) && $stable(term_100k_en))
      else $error("mode controls changed without a complete frame");

   // abort and ignore
   a_abort_clears_count: assert property (@(posedge clk) disable iff (!rst_n)
      sync_s |=> (count_reg == 5'h00) && (state_reg == ST_IDLE))
      else $error("select high did not clear shift state");
   a_abort_clears_shift: assert property (@(posedge clk) disable iff (!rst_n)
      sync_s |=> (shift_reg == 16'h0000))
      else $error("select high did not clear shift register");
   a_abort_no_update: assert property (@(posedge clk) disable iff (!rst_n)
      s_abort |=> $stable(dac_code) && $stable(power_mode) && !load_pulse)
      else $error("aborted frame changed the outputs");
   a_done_ignores_edges: assert property (@(posedge clk) disable iff (!rst_n)
      s_done_hold |=> (state_reg == ST_DONE) && !load_pulse)
      else $error("edge after the sixteenth acted");
   a_done_holds_count: assert property (@(posedge clk) disable iff (!rst_n)
      s_done_hold |=> $stable(count_reg) && $stable(shift_reg))
      else $error("edge after the sixteenth was shifted");

   // power-down decode
   a_normal_amp_on: assert property (@(posedge clk) disable iff (!rst_n)
      (power_mode == sdm_pkg::MODE_NORMAL) |-> amp_enable && !term_1k_en && !term_100k_en)
      else $error("normal mode without amplifier");
   a_pd_amp_off: assert property (@(posedge clk) disable iff (!rst_n)
      (power_mode != sdm_pkg::MODE_NORMAL) |-> !amp_enable)
      else $error("amplifier on in power down");
   a_no_double_path: assert property (@(posedge clk) disable iff (!rst_n)
      !(amp_enable && (term_1k_en || term_100k_en)) && !(term_1k_en && term_100k_en))
      else $error("output tied to two paths at once");
   a_term_decode: assert property (@(posedge clk) disable iff (!rst_n)
      (term_1k_en == (power_mode == sdm_pkg::MODE_PD_1K)) &&
      (term_100k_en == (power_mode == sdm_pkg::MODE_PD_100K)))
      else $error("termination decode wrong");
   a_hiz_all_open: assert property (@(posedge clk) disable iff (!rst_n)
      (power_mode == sdm_pkg::MODE_PD_HIZ) |-> !amp_enable && !term_1k_en && !term_100k_en)
      else $error("high impedance mode still drives the output");
endmodule : sdm_top

// ---- verif/sdm_host.sv ----
// sdm_host: host model that drives frames onto the three-wire link.
// assumes send is called at a clk falling edge; sclk idles high outside frames.
`timescale 1ns/1ps
module sdm_host (
   // link pins
   output logic sync_n,
   output logic sclk,
   output logic din
);
   initial begin
      sync_n = 1'b1;
      sclk   = 1'b1;
      din    = 1'b0;
   end
   // n bits msb first plus extra falls, then select high for 160 ns
   task automatic send(input logic [15:0] w, input int n, input int extra);
      sync_n = 1'b0;
      #160;
      for (int i = 0; i < n + extra; i++) begin
         din = (i < 16) ? w[15-i] : ~din;
         #160 sclk = 1'b0;
         #160 sclk = 1'b1;
      end
      sync_n = 1'b1;
      din    = ~din; // released line shows no stale bit
      #160;
   endtask : send
endmodule : sdm_host

// ---- verif/sdm_top_tb.sv ----
// sdm_top_tb: self-checking bench for the serial dac control.
// assumes the design loads within a few clk of the 16th shift clock fall.
`timescale 1ns/1ps
module sdm_top_tb;
   logic        clk      = 1'b0;
   logic        rst_n    = 1'b0;
   logic [11:0] exp_code = 12'h000;
   logic [1:0]  exp_mode = 2'b00;
   logic        sync_n, sclk, din, amp_enable, term_1k_en, term_100k_en, load_pulse;
   logic [11:0] dac_code;
   logic [1:0]  power_mode;
   logic [15:0] w;
   int          n_mismatch = 0, compares = 0, n_load = 0, n_exp = 0, n_cyc = 0;
   always #20 clk = ~clk;
   sdm_top i_dut (.clk(clk), .rst_n(rst_n), .sync_n(sync_n), .sclk(sclk), .din(din),
      .dac_code(dac_code), .power_mode(power_mode), .amp_enable(amp_enable),
      .term_1k_en(term_1k_en), .term_100k_en(term_100k_en), .load_pulse(load_pulse));
   sdm_host i_host (.sync_n(sync_n), .sclk(sclk), .din(din));
   // expected {amp, 1k, 100k} enables for a mode
   function automatic logic [2:0] flags(input logic [1:0] m);
      return {m == 2'b00, m == 2'b01, m == 2'b10};
   endfunction : flags
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_all;
      chk({4'h0, dac_code}, {4'h0, exp_code});
      chk({14'h0, power_mode}, {14'h0, exp_mode});
      chk({13'h0, amp_enable, term_1k_en, term_100k_en}, {13'h0, flags(exp_mode)});
   endtask : chk_all
   // one frame, then outputs and load count against expectation
   task automatic frame(input int n, input int extra);
      i_host.send(w, n, extra);
      // the host sends w on the first 16 falls, so any frame that reaches 16 loads
      if (n + extra >= 16) begin
         exp_code = w[11:0];
         exp_mode = w[13:12];
         n_exp++;
      end
      chk_all();
      chk(n_load[15:0], n_exp[15:0]);
   endtask : frame
   task automatic complete_run;
      $display("n_mismatch=%0d compares=%0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   // load pulses and the hang limit
   always @(posedge clk) begin
      n_cyc++;
      if (load_pulse === 1'b1) n_load++;
      if (n_cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   initial begin
      w = 16'($urandom(32'h0304));
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk_all();
      for (int i = 0; i < 24; i++) begin
         w = (i < 4) ? {2'($urandom), 2'(i), (i[0] ? 12'hFFF : 12'h000)} : 16'($urandom);
         frame((i % 5 == 4) ? 1 + $urandom % 15 : 16, (i % 3 == 2) ? 3 : 0);
      end
      complete_run();
   end
endmodule : sdm_top_tb
